/* logic/readback_pkg.sv */
// What this block does
// - table bits stored inverted in configuration memory
// - minor address is entry for slice 0, 15-entry for slice 1
// - frames delivered in ascending address order
// - contiguous read returns frames plus one pad
// - frame is fixed words plus one pad
// - host sends sync word then address header
// - address word holds major and minor fields
// - host writes command header then arm code
// - bit index maps to word and position
// - start words counted from major 0 minor 0
`default_nettype none
package readback_pkg;
    localparam logic [31:0] SYNC_WORD = 32'haa995566;
    localparam logic [31:0] HDR_WRITE_ADDR = 32'h30002001;
    localparam logic [31:0] HDR_WRITE_CMD = 32'h30008001;
    localparam logic [31:0] CMD_READBACK_ARM = 32'h00000004;
    localparam logic [31:0] HDR_READ_OUTPUT = 32'h28006000;
    localparam logic [31:0] HDR_READ_MASK = 32'hfffff800;
    localparam logic [31:0] FLUSH_WORD = 32'h00000000;
    localparam int MAJOR_LSB = 17;
    localparam int MAJOR_W = 8;
    localparam int MINOR_LSB = 9;
    localparam int MINOR_W = 8;
    localparam int COUNT_W = 11;
    localparam logic [7:0] FRAME_WORDS = 8'h0e;
    localparam logic [7:0] PAD_WORDS = 8'h01;
    localparam logic [7:0] MINOR_OFFSET = 8'h20;
    localparam logic [7:0] MINOR_SLICE_ADD = 8'h11;
    localparam logic [7:0] MINORS_PER_MAJOR = 8'h30;
    localparam logic [7:0] MAJOR_START_MINOR = 8'h08;
    localparam int FIFO_DEPTH = 16;
    localparam int STORE_FRAMES = 16;
    localparam int STORE_ADDR_W = 12;
    localparam logic [7:0] TABLE_WORD = 8'h0b;
    localparam logic [4:0] TABLE_BIT = 5'h06;
    localparam logic [7:0] TABLE_MAJOR = 8'h01;
endpackage
`default_nettype wire

/* logic/readback_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface readback_if;
    logic [31:0] cmd_word;
    logic cmd_valid;
    logic cmd_ready;
    logic [31:0] data_word;
    logic data_valid;
    logic data_ready;
    modport device (input cmd_word, input cmd_valid, output cmd_ready,
                    output data_word, output data_valid, input data_ready);
    modport host (output cmd_word, output cmd_valid, input cmd_ready,
                  input data_word, input data_valid, output data_ready);
endinterface
`default_nettype wire

/* logic/word_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    // fill side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // drain side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;
    assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_out = (count_reg != '0);
    assign out_data_out = mem_reg[rd_reg];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    always_ff @(posedge clock_in)
    begin
        if (push)
        begin
            mem_reg[wr_reg] <= in_data_in;
        end
        if (!rst_n_in)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_reg <= rd_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* logic/readback_device.sv */
`timescale 1ns/100ps
`default_nettype none
module readback_device (
    input wire logic clock_in,
    input wire logic rst_n_in,
    // packet port
    readback_if.device port,
    // table contents loaded by user logic
    input wire logic tbl_we_in,
    input wire logic [3:0] tbl_frame_in,
    input wire logic tbl_value_in,
    // status
    output logic armed_out,
    output logic streaming_out
);
    typedef enum logic [2:0] {WAIT_SYNC, WAIT_HDR, GET_ADDR, GET_CMD, GET_COUNT, GET_FLUSH,
                              STREAM} dev_state_e;
    typedef struct packed {
        dev_state_e state;
        logic armed;
        logic [7:0] major;
        logic [7:0] minor;
        logic [10:0] remain;
        logic [7:0] word_idx;
        logic [15:0] table_bits;
    } dev_s;
    dev_s s_reg;
    dev_s s_next;
    logic [31:0] word_val;
    logic fifo_ready;
    logic push;
    logic pad_word;
    logic last_frame;
    always_comb
    begin
        s_next = s_reg;
        push = 1'b0;
        pad_word = (s_reg.word_idx == readback_pkg::FRAME_WORDS);
        // stored (inverted) bit sits at the table slot of the minor frame
        // the closing pad frame carries no table data
        last_frame = (s_reg.remain <=
                      11'(readback_pkg::FRAME_WORDS + readback_pkg::PAD_WORDS));
        word_val = 32'h00000000;
        if (!pad_word && !last_frame && s_reg.major == readback_pkg::TABLE_MAJOR &&
            s_reg.minor < 8'h10 && s_reg.word_idx == readback_pkg::TABLE_WORD)
        begin
            // table slot follows the minor address
            word_val[readback_pkg::TABLE_BIT] = s_reg.table_bits[s_reg.minor[3:0]];
        end
        if (tbl_we_in)
        begin
            s_next.table_bits[tbl_frame_in] = ~tbl_value_in;
        end
        unique case (s_reg.state)
            WAIT_SYNC:
                if (port.cmd_valid && port.cmd_word == readback_pkg::SYNC_WORD)
                begin
                    s_next.state = WAIT_HDR;
                end
            WAIT_HDR:
                if (port.cmd_valid)
                begin
                    if (port.cmd_word == readback_pkg::HDR_WRITE_ADDR)
                    begin
                        s_next.state = GET_ADDR;
                    end
                    else if (port.cmd_word == readback_pkg::HDR_WRITE_CMD)
                    begin
                        s_next.state = GET_CMD;
                    end
                    else if (s_reg.armed && (port.cmd_word & readback_pkg::HDR_READ_MASK) ==
                             readback_pkg::HDR_READ_OUTPUT)
                    begin
                        s_next.remain = port.cmd_word[readback_pkg::COUNT_W-1:0];
                        s_next.state = GET_FLUSH;
                    end
                end
            GET_ADDR:
                if (port.cmd_valid)
                begin
                    s_next.major =
                        port.cmd_word[readback_pkg::MAJOR_LSB +: readback_pkg::MAJOR_W];
                    s_next.minor =
                        port.cmd_word[readback_pkg::MINOR_LSB +: readback_pkg::MINOR_W];
                    // stream starts at the loaded frame, not at frame zero
                    s_next.word_idx = 8'h00;
                    s_next.state = WAIT_HDR;
                end
            GET_CMD:
                if (port.cmd_valid)
                begin
                    s_next.armed = (port.cmd_word == readback_pkg::CMD_READBACK_ARM);
                    s_next.state = WAIT_HDR;
                end
            GET_COUNT:
                s_next.state = WAIT_HDR;
            GET_FLUSH:
                if (port.cmd_valid)
                begin
                    s_next.state = (s_reg.remain == '0) ? WAIT_HDR : STREAM;
                end
            STREAM:
                if (fifo_ready)
                begin
                    push = 1'b1;
                    s_next.remain = s_reg.remain - 11'h001;
                    if (pad_word)
                    begin
                        s_next.word_idx = 8'h00;
                        s_next.minor = s_reg.minor + 8'h01;
                    end
                    else
                    begin
                        s_next.word_idx = s_reg.word_idx + 8'h01;
                    end
                    if (s_reg.remain == 11'h001)
                    begin
                        s_next.armed = 1'b0;
                        s_next.state = WAIT_HDR;
                    end
                end
        endcase
    end
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            s_reg <= '{state: WAIT_SYNC, armed: 1'b0, major: 8'h00, minor: 8'h00,
                       remain: 11'h000, word_idx: 8'h00, table_bits: 16'h0000};
        end
        else
        begin
            s_reg <= s_next;
        end
    end
    assign port.cmd_ready = (s_reg.state != STREAM);
    assign armed_out = s_reg.armed;
    assign streaming_out = (s_reg.state == STREAM);
    word_fifo #(.WIDTH(32), .DEPTH(readback_pkg::FIFO_DEPTH)) out_fifo (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .in_data_in(word_val),
        .in_valid_in(push),
        .in_ready_out(fifo_ready),
        .out_data_out(port.data_word),
        .out_valid_out(port.data_valid),
        .out_ready_in(port.data_ready)
    );
endmodule
`default_nettype wire

/* logic/readback_host.sv */
`timescale 1ns/100ps
`default_nettype none
module readback_host (
    input wire logic clock_in,
    input wire logic rst_n_in,
    // packet port
    readback_if.host port,
    // user request
    input wire logic start_in,
    input wire logic slice_in,
    input wire logic [7:0] major_in,
    input wire logic [7:0] frames_in,
    // user results
    output logic busy_out,
    output logic [31:0] word_out,
    output logic word_valid_out,
    output logic [15:0] table_out
);
    typedef enum logic [3:0] {IDLE, SYNC, ADDR_HDR, ADDR_VAL, CMD_HDR, CMD_VAL, RD_HDR, FLUSH,
                              DRAIN} host_state_e;
    typedef struct packed {
        host_state_e state;
        logic [7:0] major;
        logic [7:0] frames;
        logic slice;
        logic [10:0] remain;
        logic [7:0] word_idx;
        logic [7:0] frame_no;
        logic [31:0] word;
        logic word_valid;
        logic [15:0] table_bits;
    } host_s;
    host_s s_reg;
    host_s s_next;
    logic [10:0] total;
    logic [7:0] entry;
    always_comb
    begin
        s_next = s_reg;
        s_next.word_valid = 1'b0;
        // words of the frames plus one pad frame
        total = 11'(({3'b000, s_reg.frames} + 11'h001) *
                    {3'b000, readback_pkg::FRAME_WORDS + readback_pkg::PAD_WORDS});
        // frame k ascending holds entry k for slice 0, entry 15-k for slice 1
        entry = s_reg.slice ? (8'h0f - s_reg.frame_no) : s_reg.frame_no;
        port.cmd_valid = 1'b0;
        port.cmd_word = 32'h00000000;
        unique case (s_reg.state)
            IDLE:
                if (start_in)
                begin
                    s_next.major = major_in;
                    s_next.frames = frames_in;
                    s_next.slice = slice_in;
                    s_next.state = SYNC;
                end
            SYNC:
            begin
                port.cmd_valid = 1'b1;
                port.cmd_word = readback_pkg::SYNC_WORD;
            end
            ADDR_HDR:
            begin
                port.cmd_valid = 1'b1;
                port.cmd_word = readback_pkg::HDR_WRITE_ADDR;
            end
            ADDR_VAL:
            begin
                port.cmd_valid = 1'b1;
                port.cmd_word[readback_pkg::MAJOR_LSB +: readback_pkg::MAJOR_W] =
                    s_reg.major;
            end
            CMD_HDR:
            begin
                port.cmd_valid = 1'b1;
                port.cmd_word = readback_pkg::HDR_WRITE_CMD;
            end
            CMD_VAL:
            begin
                port.cmd_valid = 1'b1;
                port.cmd_word = readback_pkg::CMD_READBACK_ARM;
            end
            RD_HDR:
            begin
                port.cmd_valid = 1'b1;
                port.cmd_word = readback_pkg::HDR_READ_OUTPUT | {21'h00000, total};
            end
            FLUSH:
            begin
                port.cmd_valid = 1'b1;
                port.cmd_word = readback_pkg::FLUSH_WORD;
            end
            DRAIN:
                if (port.data_valid)
                begin
                    s_next.word = port.data_word;
                    s_next.word_valid = 1'b1;
                    s_next.remain = s_reg.remain - 11'h001;
                    // pad frame at the tail must not touch the table
                    if (s_reg.word_idx == readback_pkg::TABLE_WORD &&
                        s_reg.frame_no < s_reg.frames && s_reg.frame_no < 8'h10)
                    begin
                        s_next.table_bits[entry[3:0]] =
                            ~port.data_word[readback_pkg::TABLE_BIT];
                    end
                    if (s_reg.word_idx == readback_pkg::FRAME_WORDS)
                    begin
                        s_next.word_idx = 8'h00;
                        s_next.frame_no = s_reg.frame_no + 8'h01;
                    end
                    else
                    begin
                        s_next.word_idx = s_reg.word_idx + 8'h01;
                    end
                    if (s_reg.remain == 11'h001)
                    begin
                        s_next.state = IDLE;
                    end
                end
        endcase
        if (port.cmd_valid && port.cmd_ready)
        begin
            unique case (s_reg.state)
                SYNC: s_next.state = ADDR_HDR;
                ADDR_HDR: s_next.state = ADDR_VAL;
                ADDR_VAL: s_next.state = CMD_HDR;
                CMD_HDR: s_next.state = CMD_VAL;
                CMD_VAL: s_next.state = RD_HDR;
                RD_HDR: s_next.state = FLUSH;
                FLUSH:
                begin
                    s_next.remain = total;
                    s_next.word_idx = 8'h00;
                    s_next.frame_no = 8'h00;
                    s_next.state = DRAIN;
                end
                default: s_next.state = s_reg.state;
            endcase
        end
    end
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            s_reg <= '{state: IDLE, major: 8'h00, frames: 8'h00, slice: 1'b0,
                       remain: 11'h000, word_idx: 8'h00, frame_no: 8'h00,
                       word: 32'h00000000, word_valid: 1'b0, table_bits: 16'h0000};
        end
        else
        begin
            s_reg <= s_next;
        end
    end
    assign port.data_ready = (s_reg.state == DRAIN);
    assign busy_out = (s_reg.state != IDLE);
    assign word_out = s_reg.word;
    assign word_valid_out = s_reg.word_valid;
    assign table_out = s_reg.table_bits;
endmodule
`default_nettype wire

/* tb/readback_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module readback_sva (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // carrier signals
    input wire logic [31:0] cmd_word,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [31:0] data_word,
    input wire logic data_valid,
    input wire logic data_ready
);
    // =====
    // helper tracking
    logic [2:0] step_reg;
    logic [10:0] count_reg;
    logic [10:0] popped_reg;
    logic take;
    logic pop;
    assign take = cmd_valid && cmd_ready;
    assign pop = data_valid && data_ready;
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            step_reg <= 3'h0;
            count_reg <= 11'h000;
            popped_reg <= 11'h000;
        end
        else
        begin
            if (take)
                step_reg <= (step_reg == 3'h6) ? 3'h0 : step_reg + 3'h1;
            if (take && step_reg == 3'h5)
                count_reg <= cmd_word[10:0];
            if (take && step_reg == 3'h5)
                popped_reg <= 11'h000;
            else if (pop)
                popped_reg <= popped_reg + 11'h001;
        end
    end
    // =====
    // packet order and stream bounds
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    property p_sync; take && step_reg == 3'h0 |-> cmd_word == readback_pkg::SYNC_WORD; endproperty
    a_sync: assert property (p_sync) else $error("first word not sync");
    property p_addr_hdr;
        take && step_reg == 3'h1 |-> cmd_word == readback_pkg::HDR_WRITE_ADDR;
    endproperty
    a_addr_hdr: assert property (p_addr_hdr) else $error("address header wrong");
    property p_addr; take && step_reg == 3'h2 |-> cmd_word[8:0] == 9'h000; endproperty
    a_addr: assert property (p_addr) else $error("address word low bits set");
    property p_cmd;
        take && step_reg == 3'h3 |-> cmd_word == readback_pkg::HDR_WRITE_CMD;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command header wrong");
    property p_arm; take && step_reg == 3'h4 |-> cmd_word == readback_pkg::CMD_READBACK_ARM;
    endproperty
    a_arm: assert property (p_arm) else $error("arm code wrong");
    property p_rd; take && step_reg == 3'h5 |-> (cmd_word & readback_pkg::HDR_READ_MASK)
        == readback_pkg::HDR_READ_OUTPUT && cmd_word[10:0] % 15 == 0; endproperty
    a_rd: assert property (p_rd) else $error("read header or count wrong");
    property p_flush; take && step_reg == 3'h6 |-> cmd_word == 32'h0 ##2 data_valid; endproperty
    a_flush: assert property (p_flush) else $error("flush or first data late");
    property p_bound; pop |-> popped_reg < count_reg; endproperty
    a_bound: assert property (p_bound) else $error("more words than requested");
    property p_stop; pop && popped_reg == count_reg - 11'h001 |=> !data_valid; endproperty
    a_stop: assert property (p_stop) else $error("data after last word");
    property p_busy; $rose(data_valid) |-> !cmd_ready; endproperty
    a_busy: assert property (p_busy) else $error("command port open while streaming");
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // =====
    // stimulus and observation
    logic clock_in, rst_n_in, start_in, slice_in, tbl_we_in, tbl_value_in;
    logic [7:0] major_in, frames_in;
    logic [3:0] tbl_frame_in;
    logic busy_out, word_valid_out, armed_out, streaming_out;
    logic [31:0] word_out;
    logic [15:0] table_out, tbl;
    int n_mismatch, n_tests;
    logic timed_out;
    integer seed = 32'hb1ed5699;
    readback_if rb();
    readback_host i_readback_host (.clock_in(clock_in), .rst_n_in(rst_n_in), .port(rb),
        .start_in(start_in), .slice_in(slice_in), .major_in(major_in), .frames_in(frames_in),
        .busy_out(busy_out), .word_out(word_out), .word_valid_out(word_valid_out),
        .table_out(table_out));
    readback_device i_readback_device (.clock_in(clock_in), .rst_n_in(rst_n_in), .port(rb),
        .tbl_we_in(tbl_we_in), .tbl_frame_in(tbl_frame_in), .tbl_value_in(tbl_value_in),
        .armed_out(armed_out), .streaming_out(streaming_out));
    readback_sva i_readback_sva (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .cmd_word(rb.cmd_word), .cmd_valid(rb.cmd_valid), .cmd_ready(rb.cmd_ready),
        .data_word(rb.data_word), .data_valid(rb.data_valid), .data_ready(rb.data_ready));
    // =====
    // helpers
    function automatic logic [31:0] exp_word(int idx, logic [7:0] maj, logic [7:0] frm);
        logic [31:0] w;
        w = 32'h0;
        if (maj == 8'h01 && idx / 15 < frm && idx % 15 == 11)
            w[6] = ~tbl[idx / 15];
        return w;
    endfunction
    task automatic final_report();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic load(logic [15:0] v);
        tbl = v;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clock_in);
            tbl_we_in <= 1'b1;
            tbl_frame_in <= 4'(i);
            tbl_value_in <= v[i];
        end
        @(posedge clock_in);
        tbl_we_in <= 1'b0;
    endtask
    // tail keeps watching after busy drops to catch stray words
    task automatic run(logic slc, logic [7:0] maj, logic [7:0] frm);
        int n, tail;
        logic [15:0] want;
        if (timed_out)
            return;
        n = 0;
        tail = 0;
        @(posedge clock_in);
        start_in <= 1'b1;
        slice_in <= slc;
        major_in <= maj;
        frames_in <= frm;
        @(posedge clock_in);
        start_in <= 1'b0;
        for (int cyc = 0; cyc < 2000 && tail < 20; cyc++)
        begin
            @(posedge clock_in);
            #1;
            if (word_valid_out === 1'b1)
            begin
                check("word", word_out, exp_word(n, maj, frm));
                n++;
            end
            if (busy_out !== 1'b1)
                tail++;
        end
        // a hung run is counted once; later runs are skipped
        if (tail < 20)
        begin
            n_mismatch++;
            timed_out = 1'b1;
            return;
        end
        check("count", n, (frm + 1) * 15);
        check("armed", {31'h0, armed_out}, 32'h0);
        check("stream", {31'h0, streaming_out | rb.data_valid}, 32'h0);
        for (int k = 0; k < 16; k++)
            want[k] = slc ? tbl[15 - k] : tbl[k];
        if (maj == 8'h01 && frm == 8'h10)
            check("table", {16'h0, table_out}, {16'h0, want});
    endtask
    // =====
    // clock and main sequence
    initial
    begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    initial
    begin
        rst_n_in = 1'b0;
        start_in = 1'b0;
        slice_in = 1'b0;
        major_in = 8'h00;
        frames_in = 8'h00;
        tbl_we_in = 1'b0;
        tbl_frame_in = 4'h0;
        tbl_value_in = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        timed_out = 1'b0;
        tbl = 16'h0;
        repeat (12) @(posedge clock_in);
        rst_n_in <= 1'b1;
        // and-gate pattern in both slice orders, then edge counts
        load(16'h8000);
        run(1'b0, 8'h01, 8'h10);
        run(1'b1, 8'h01, 8'h10);
        run(1'b0, 8'h01, 8'h01);
        run(1'b1, 8'h02, 8'h03);
        repeat (8)
        begin
            load(16'($random(seed)));
            run(1'($random(seed)), ($random(seed) % 4 == 0) ? 8'h05 : 8'h01,
                8'h01 + 8'($unsigned($random(seed)) % 16));
            run(1'($random(seed)), 8'h01, 8'h10);
        end
        final_report();
    end
endmodule
`default_nettype wire
